// ===== verilog/event_sequence_recorder.sv
`timescale 1ns/10ps
`include "esr_regs.svh"

//==============================================================
// Event FIFO
module event_fifo #(
  parameter int W = 132,
  parameter int D = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         wr_valid_in,
  output logic              wr_ready_out,
  input  wire logic [W-1:0] wr_data_in,
  output logic              rd_valid_out,
  input  wire logic         rd_ready_in,
  output logic [W-1:0]      rd_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   n_q, n_d;
  logic          wr, rd;

  assign wr_ready_out = n_q != (AW+1)'(D);
  assign rd_valid_out = n_q != '0;
  assign rd_data_out  = mem_q[rp_q];

  always_comb begin
    wr   = wr_valid_in && wr_ready_out;
    rd   = rd_valid_out && rd_ready_in;
    wp_d = wr ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = rd ? AW'(rp_q + 1'b1) : rp_q;
    n_d  = (AW+1)'(n_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_q <= '0;
      rp_q <= '0;
      n_q  <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      n_q  <= n_d;
    end
  end

  // Storage needs no reset; empty entries reach rd_data_out only while rd_valid_out is low
  always_ff @(posedge clk_in) begin
    if (wr) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end
endmodule

//==============================================================
// One input point: debounce, trigger, dead time
module esr_point
  import esr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        tick_ms_in,
  input  wire logic        tick_dead_in,
  input  wire logic        pin_in,
  input  wire logic [1:0]  trig_in,
  input  wire logic [7:0]  deb_in,
  input  wire logic [14:0] dead_in,
  input  wire logic        ack_in,
  input  wire logic        done_in,
  output logic             req_out,
  output logic             level_out
);
  pt_state_t   st_q, st_d;
  logic        stable_q, stable_d, req_q, req_d, lvl_q, lvl_d, change, qual;
  logic [7:0]  deb_q, deb_d;
  logic [14:0] dcnt_q, dcnt_d;

  assign req_out   = req_q;
  assign level_out = lvl_q;

  always_comb begin
    stable_d = stable_q;
    deb_d    = deb_q;
    change   = 1'b0;
    if (pin_in == stable_q) begin
      deb_d = '0;
    end else if (tick_ms_in) begin
      if (deb_q >= deb_in) begin
        stable_d = pin_in;
        deb_d    = '0;
        change   = 1'b1;
      end else begin
        deb_d = deb_q + 8'h01;
      end
    end
    qual   = change && (pin_in ? trig_in[0] : trig_in[1]);
    st_d   = st_q;
    dcnt_d = dcnt_q;
    req_d  = req_q && !ack_in;
    lvl_d  = lvl_q;
    case (st_q)
      PT_ARMED: begin
        if (qual) begin
          req_d = 1'b1;
          lvl_d = pin_in;
          if (dead_in == '0) begin
            st_d = PT_WAIT;
          end else begin
            st_d   = PT_DEAD;
            dcnt_d = dead_in;
          end
        end
      end
      PT_DEAD: begin
        if (tick_dead_in && dcnt_q != '0) begin
          dcnt_d = dcnt_q - 15'h0001;
        end
        if (dcnt_q == '0 && !req_q) begin
          st_d = PT_ARMED;
        end
      end
      PT_WAIT: begin
        if (done_in) begin
          st_d = PT_ARMED;
        end
      end
      default: st_d = PT_ARMED;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q     <= PT_ARMED;
      stable_q <= 1'b0;
      deb_q    <= '0;
      dcnt_q   <= '0;
      req_q    <= 1'b0;
      lvl_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      stable_q <= stable_d;
      deb_q    <= deb_d;
      dcnt_q   <= dcnt_d;
      req_q    <= req_d;
      lvl_q    <= lvl_d;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_edge;
    st_q == PT_ARMED && qual;
  endsequence
  AST_REPORT_EDGE: assert property (s_edge |=> req_q && lvl_q == $past(pin_in))
    else $error("qualified edge not reported");
  AST_DISABLED_QUIET: assert property (trig_in == 2'b00 |-> !qual)
    else $error("disabled point qualified an edge");
  AST_DEAD_SILENT: assert property (st_q == PT_DEAD && dcnt_q != '0 |=> st_q != PT_ARMED)
    else $error("dead time ended early");
  AST_WAIT_HOLD: assert property (st_q == PT_WAIT && !done_in |=> st_q == PT_WAIT)
    else $error("zero dead time rearmed before collection");
  AST_DEB_STABLE: assert property (change |-> deb_q >= deb_in && pin_in != stable_q ##1
                                   stable_q == $past(pin_in))
    else $error("change accepted before debounce");
endmodule

//==============================================================
// Top: arbiter, block policies, time stamp
module event_sequence_recorder
  import esr_pkg::*;
#(
  parameter int MS_CYCLES = `ESR_MS_CYC
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [3:0]   point_in,
  input  wire logic [7:0]   trig_sel_in,
  input  wire logic [31:0]  debounce_ms_in,
  input  wire logic [59:0]  dead_time_in,
  input  wire logic [15:0]  block_sel_in,
  input  wire logic [47:0]  block_type_in,
  input  wire logic [255:0] block_cap_in,
  input  wire logic [15:0]  block_clear_in,
  output logic              evt_valid_out,
  input  wire logic         evt_ready_in,
  output logic [3:0]        evt_block_out,
  output logic [63:0]       evt_stamp_out,
  output logic [63:0]       evt_data_out,
  output logic [255:0]      block_count_out,
  output logic [15:0]       block_stopped_out,
  output logic              config_err_out
);
  localparam int NP = `ESR_NPTS;
  localparam int NB = `ESR_NBLK;

  logic        rs1_q, rs2_q, rst_n;
  logic [15:0] div_q, div_d;
  logic [3:0]  tdiv_q, tdiv_d;
  stamp_t      ts_q, ts_d;
  logic        tick_ms, tick_dead, err_q, err_d;
  logic [NP-1:0] req, lvl, ack, done;
  blk_type_t   etype [NB];
  logic [15:0] cap [NB];
  logic [15:0] cnt_q [NB];
  logic [15:0] cnt_d [NB];
  logic [NB-1:0] stop_q, stop_d;
  logic [1:0]  sel;
  logic [3:0]  tb, pop_blk;
  logic        any, accept, take, fifo_wr, fifo_rdy, pop, full, consume;
  logic [15:0] tcnt, tcap, pop_cnt;
  blk_type_t   tty;
  logic [`ESR_FIFO_W-1:0] fifo_out;

  // Reset release through two stages
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_n = rs2_q;

  //==============================================================
  // Time base
  always_comb begin
    tick_ms   = div_q == 16'(MS_CYCLES - 1);
    tick_dead = tick_ms && tdiv_q == `ESR_DEAD_DIV;
    div_d     = tick_ms ? '0 : div_q + 16'h0001;
    tdiv_d    = tick_dead ? '0 : (tick_ms ? tdiv_q + 4'h1 : tdiv_q);
    ts_d      = tick_ms ? ts_q + 64'h1 : ts_q;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= '0;
      tdiv_q <= '0;
      ts_q   <= '0;
      err_q  <= 1'b0;
    end else begin
      div_q  <= div_d;
      tdiv_q <= tdiv_d;
      ts_q   <= ts_d;
      err_q  <= err_d;
    end
  end

  //==============================================================
  // Points
  for (genvar i = 0; i < NP; i++) begin : g_pt
    esr_point u_pt (
      .clk_in       (clk_in),
      .rstn_in      (rst_n),
      .tick_ms_in   (tick_ms),
      .tick_dead_in (tick_dead),
      .pin_in       (point_in[i]),
      .trig_in      (trig_sel_in[2*i +: 2]),
      .deb_in       (debounce_ms_in[8*i +: 8]),
      .dead_in      (dead_time_in[15*i +: 15]),
      .ack_in       (ack[i]),
      .done_in      (done[i]),
      .req_out      (req[i]),
      .level_out    (lvl[i])
    );
  end

  //==============================================================
  // Block configuration check
  always_comb begin
    logic [19:0] sum;
    logic        ok;
    sum   = '0;
    ok    = 1'b0;
    err_d = 1'b0;
    for (int b = 0; b < NB; b++) begin
      etype[b] = block_type_in[3*b +: 3];
      if (b >= 14) begin
        ok = etype[b] == `ESR_TY_MODEXT;
      end else begin
        ok = etype[b] inside {`ESR_TY_EXT, `ESR_TY_FIRST, `ESR_TY_HIST, `ESR_TY_ALARM};
      end
      if (!ok) begin
        err_d    = err_d || etype[b] != `ESR_TY_NONE;
        etype[b] = `ESR_TY_NONE;
      end
      cap[b] = block_cap_in[16*b +: 16];
      if (cap[b] > `ESR_CAP_MAX) begin
        cap[b] = `ESR_CAP_MAX;
        err_d  = 1'b1;
      end
      sum = sum + {4'h0, cap[b]};
    end
    if (sum > `ESR_CAP_SUM) begin
      err_d = 1'b1;
    end
  end

  //==============================================================
  // Arbiter and block policies
  always_comb begin
    any = 1'b0;
    sel = '0;
    for (int i = 0; i < NP; i++) begin
      if (req[i] && !any) begin
        any = 1'b1;
        sel = 2'(i);
      end
    end
    tb   = block_sel_in[4*sel +: 4];
    tty  = etype[tb];
    tcnt = cnt_q[tb];
    tcap = cap[tb];
    full = tcnt >= tcap;
    case (tty)
      `ESR_TY_EXT, `ESR_TY_MODEXT, `ESR_TY_ALARM: accept = !full;
      `ESR_TY_FIRST: accept = !full && !stop_q[tb];
      `ESR_TY_HIST: accept = tcap != '0;
      default: accept = 1'b0;
    endcase
    take    = any && (!accept || fifo_rdy);
    fifo_wr = take && accept;
    pop     = evt_valid_out && evt_ready_in;
    pop_blk = fifo_out[131:128];
    pop_cnt = cnt_q[pop_blk];
    consume = etype[pop_blk] inside {`ESR_TY_EXT, `ESR_TY_MODEXT, `ESR_TY_ALARM};
    ack     = '0;
    done    = '0;
    ack[sel] = take;
    done[sel] = take && !accept;
    if (pop) begin
      done[fifo_out[2:1]] = 1'b1;
    end
    for (int b = 0; b < NB; b++) begin
      cnt_d[b]  = block_clear_in[b] ? `ESR_CNT_RST : cnt_q[b];
      stop_d[b] = stop_q[b] && !block_clear_in[b];
      if (pop && consume && pop_blk == 4'(b) && cnt_d[b] != '0) begin
        cnt_d[b] = cnt_d[b] - 16'h0001;
      end
      if (fifo_wr && tb == 4'(b) && !(tty == `ESR_TY_HIST && cnt_d[b] >= tcap)) begin
        cnt_d[b] = cnt_d[b] + 16'h0001;
      end
      // full first-out stops; set beats clear
      if (any && tb == 4'(b) && tty == `ESR_TY_FIRST &&
          (full || (fifo_wr && tcnt + 16'h0001 >= tcap))) begin
        stop_d[b] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stop_q <= '0;
      for (int b = 0; b < NB; b++) begin
        cnt_q[b] <= `ESR_CNT_RST;
      end
    end else begin
      stop_q <= stop_d;
      for (int b = 0; b < NB; b++) begin
        cnt_q[b] <= cnt_d[b];
      end
    end
  end

  always_comb begin
    for (int b = 0; b < NB; b++) begin
      block_count_out[16*b +: 16] = cnt_q[b];
    end
  end
  assign block_stopped_out = stop_q;
  assign config_err_out    = err_q;

  //==============================================================
  // Entry path; once the FIFO is full, a stalled collector holds requests for accepting blocks
  // stamp then data word
  event_fifo #(
    .W (`ESR_FIFO_W),
    .D (`ESR_FIFO_D)
  ) u_fifo (
    .clk_in       (clk_in),
    .rstn_in      (rst_n),
    .wr_valid_in  (fifo_wr),
    .wr_ready_out (fifo_rdy),
    .wr_data_in   ({tb, ts_q, 61'h0, sel, lvl[sel]}),
    .rd_valid_out (evt_valid_out),
    .rd_ready_in  (evt_ready_in),
    .rd_data_out  (fifo_out)
  );
  assign evt_block_out = fifo_out[131:128];
  assign evt_stamp_out = fifo_out[127:64];
  assign evt_data_out  = fifo_out[63:0];

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  AST_STAMP_TICK: assert property (tick_ms |=> ts_q == $past(ts_q) + 64'h1)
    else $error("stamp did not advance on ms tick");
  AST_UNASSIGNED_DROP: assert property (any && tty == `ESR_TY_NONE |-> !fifo_wr)
    else $error("unassigned block took an entry");
  AST_MODEXT_ONLY: assert property (fifo_wr && tb >= `ESR_MODEXT_LO |-> tty == `ESR_TY_MODEXT)
    else $error("reserved block took wrong type");
  AST_FULL_DROP: assert property (any && full && tty != `ESR_TY_HIST |-> !fifo_wr)
    else $error("full block accepted an entry");
  AST_ALARM_DROP: assert property (any && full && tty == `ESR_TY_ALARM |-> !fifo_wr)
    else $error("full alarm block accepted an entry");
  sequence s_fill_first;
    fifo_wr && tty == `ESR_TY_FIRST && tcnt + 16'h0001 == tcap;
  endsequence
  AST_FIRST_STOP: assert property (s_fill_first |=> stop_q[$past(tb)] ##1
                                   (stop_q[$past(tb, 2)] ||
                                    |($past(block_clear_in) & (16'h0001 << $past(tb, 2)))))
    else $error("first-out block did not stop when full");
  AST_HIST_KEEP: assert property (pop && etype[pop_blk] == `ESR_TY_HIST && !fifo_wr &&
                                  !block_clear_in[pop_blk] |=> cnt_q[$past(pop_blk)] ==
                                  $past(pop_cnt))
    else $error("history read removed an entry");
  AST_CAP_LIMIT: assert property (block_cap_in[16*tb +: 16] > `ESR_CAP_MAX |->
                                  cap[tb] == `ESR_CAP_MAX ##1 err_q)
    else $error("capacity above limit");
endmodule

// ===== verilog/esr_regs.svh
//==============================================================
`ifndef ESR_REGS_SVH
`define ESR_REGS_SVH
`define ESR_NPTS      4
`define ESR_NBLK      16
`define ESR_MODEXT_LO 4'he
`define ESR_TY_NONE   3'h0
`define ESR_TY_EXT    3'h1
`define ESR_TY_FIRST  3'h2
`define ESR_TY_HIST   3'h3
`define ESR_TY_MODEXT 3'h4
`define ESR_TY_ALARM  3'h5
`define ESR_CAP_MAX   16'h4e20
`define ESR_CAP_SUM   20'h0ea60
`define ESR_CNT_RST   16'h0000
`define ESR_CLK_HZ    50000000
`define ESR_STAMP_MS  1
`define ESR_MS_CYC    (`ESR_CLK_HZ / 1000 * `ESR_STAMP_MS)
`define ESR_DEAD_MS   10
`define ESR_DEAD_DIV  4'h9
`define ESR_FIFO_D    8
`define ESR_FIFO_W    132
`endif

// ===== verilog/esr_pkg.sv
package esr_pkg;
  typedef enum logic [1:0] {PT_ARMED, PT_DEAD, PT_WAIT} pt_state_t;
  typedef logic [2:0]  blk_type_t;
  typedef logic [63:0] stamp_t;
endpackage

// ===== verif/esr_collector.sv
`timescale 1ns/10ps
//==============================================================
// Collector on the far side of the event stream
module esr_collector (
  input  wire logic stall_in,
  input  wire logic valid_in,
  output logic      ready_out,
  output logic      take_out
);
  assign ready_out = !stall_in;
  assign take_out  = valid_in && ready_out;
endmodule

// ===== verif/event_sequence_recorder_tb.sv
`timescale 1ns/10ps
//==============================================================
// Bench for the recorder
module event_sequence_recorder_tb;
  import esr_pkg::*;
  localparam int MS = 20;
  logic         clk_in, rstn_in, stall, rnd, ready, valid, err;
  logic [3:0]   pt, blk_o;
  logic [7:0]   trig;
  logic [31:0]  deb;
  logic [59:0]  dead;
  logic [15:0]  bsel, bclr, stop;
  logic [47:0]  btype, sv_t;
  logic [255:0] bcap, cnt, sv_c;
  stamp_t       stamp, last;
  logic [63:0]  data;
  int           bad_count, tests_run;
  int           exp_q[$];
  int           kb[3] = '{1, 4, 15};
  blk_type_t    kt[3] = '{3'h1, 3'h5, 3'h4};

  event_sequence_recorder #(.MS_CYCLES(MS)) dut_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .point_in(pt), .trig_sel_in(trig),
    .debounce_ms_in(deb), .dead_time_in(dead), .block_sel_in(bsel),
    .block_type_in(btype), .block_cap_in(bcap), .block_clear_in(bclr),
    .evt_valid_out(valid), .evt_ready_in(ready), .evt_block_out(blk_o),
    .evt_stamp_out(stamp), .evt_data_out(data), .block_count_out(cnt),
    .block_stopped_out(stop), .config_err_out(err)
  );
  esr_collector coll_u (.stall_in(stall), .valid_in(valid), .ready_out(ready), .take_out());

  initial begin
    clk_in = 0;
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    #1;
    if (rnd) stall = 1'($urandom_range(1, 0));
  end

  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  // Model: expected entries queue in order
  always @(negedge clk_in) begin
    int e;
    if (valid === 1'b1 && ready === 1'b1) begin
      chk(exp_q.size() > 0, "extra entry");
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 0;
      chk(blk_o === 4'(e >> 3) && data === {61'h0, 3'(e)}, "entry differs");
      chk(stamp >= last, "stamp order");
      last = stamp;
    end
  end

  task automatic ms(input int n);
    repeat (n * MS) @(posedge clk_in);
    #1;
  endtask

  task automatic pcfg(input int p, input logic [1:0] t, input logic [7:0] d,
                      input logic [14:0] dt, input logic [3:0] b);
    trig[2*p+:2] = t;
    deb[8*p+:8] = d;
    dead[15*p+:15] = dt;
    bsel[4*p+:4] = b;
  endtask

  task automatic bcfg(input int b, input blk_type_t t, input logic [15:0] c);
    btype[3*b+:3] = t;
    bcap[16*b+:16] = c;
  endtask

  task automatic ev(input int p, input int b, input bit push, input int gap);
    pt[p] = ~pt[p];
    if (push) exp_q.push_back(b * 8 + p * 2 + int'(pt[p]));
    ms(gap);
  endtask

  // Random stalls while emptying; limit keeps a hang short
  task automatic drain();
    rnd = 1;
    for (int i = 0; i < 4000 && exp_q.size() > 0; i++) @(posedge clk_in);
    rnd = 0;
    #1 stall = 0;
    ms(2);
    chk(exp_q.size() == 0, "entry missing");
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    bad_count++;
    $display("ERROR %0t watchdog", $time);
    print_verdict();
  end

  initial begin
    void'($urandom(32'hf38b));
    {stall, rnd, pt, trig, deb, dead, bsel, bclr, btype, bcap, last} = '0;
    rstn_in = 0;
    repeat (8) @(posedge clk_in);
    #1 rstn_in = 1;
    ms(1);
    chk(valid === 1'b0 && cnt === '0 && stop === '0 && err === 1'b0, "reset");
    pcfg(0, 2'h3, 8'h0, 15'h0, 4'h0);
    ev(0, 0, 0, 5);
    ev(0, 0, 0, 5);
    chk(cnt === '0, "unassigned");
    bcfg(0, 3'h1, 16'd100);
    for (int p = 0; p < 4; p++) pcfg(p, 2'(p), 8'h0, 15'h0, 4'h0);
    for (int p = 0; p < 4; p++) ev(p, 0, p[0], 0);
    ms(5);
    for (int p = 0; p < 4; p++) ev(p, 0, p[1], 0);
    ms(5);
    drain();
    pcfg(3, 2'h3, 8'd5, 15'h0, 4'h0);
    ev(3, 0, 0, 2);
    ev(3, 0, 0, 10);
    ev(3, 0, 1, 10);
    ev(3, 0, 1, 10);
    pcfg(3, 2'h3, 8'h0, 15'h0, 4'h0);
    ev(3, 0, 1, 2);
    ev(3, 0, 1, 5);
    drain();
    pcfg(1, 2'h1, 8'h0, 15'd3, 4'h0);
    ev(1, 0, 1, 2);
    ev(1, 0, 0, 2);
    ev(1, 0, 0, 40);
    drain();
    pcfg(1, 2'h0, 8'h0, 15'h0, 4'h0);
    ev(1, 0, 0, 2);
    // FIFO fill: eight entries, ninth held back
    stall = 1;
    for (int p = 0; p < 4; p++) pcfg(p, 2'h3, 8'h0, 15'd1, 4'h0);
    for (int r = 0; r < 2; r++)
      for (int p = 0; p < 4; p++) ev(p, 0, 1, (p == 3) ? 25 : 0);
    ev(0, 0, 1, 25);
    chk(valid === 1'b1 && cnt[15:0] === 16'd8, "fifo full");
    drain();
    chk(cnt[15:0] === 16'h0, "ext count");
    for (int p = 1; p < 4; p++) pcfg(p, 2'h0, 8'h0, 15'h0, 4'h0);
    for (int k = 0; k < 3; k++) begin
      bcfg(kb[k], kt[k], 16'd2);
      pcfg(0, 2'h3, 8'h0, 15'd1, 4'(kb[k]));
      stall = 1;
      for (int i = 0; i < 3; i++) ev(0, kb[k], i < 2, 25);
      chk(cnt[16*kb[k]+:16] === 16'd2 && err === 1'b0, "full block");
      drain();
      chk(cnt[16*kb[k]+:16] === 16'h0, "pop count");
    end
    bcfg(2, 3'h2, 16'd1);
    pcfg(0, 2'h3, 8'h0, 15'd1, 4'h2);
    ev(0, 2, 1, 25);
    ev(0, 2, 0, 25);
    chk(stop[2] === 1'b1 && cnt[47:32] === 16'd1, "stopped");
    bclr[2] = 1;
    @(posedge clk_in);
    #1 bclr = '0;
    ms(1);
    chk(stop[2] === 1'b0 && cnt[47:32] === 16'h0, "clear");
    ev(0, 2, 1, 25);
    drain();
    chk(cnt[47:32] === 16'd1, "first count");
    bcfg(3, 3'h3, 16'd2);
    pcfg(0, 2'h3, 8'h0, 15'd1, 4'h3);
    for (int i = 0; i < 3; i++) ev(0, 3, 1, 25);
    drain();
    chk(cnt[63:48] === 16'd2, "history count");
    // Zero dead time: second change lost until the first entry is collected
    pcfg(0, 2'h3, 8'h0, 15'h0, 4'h0);
    stall = 1;
    ev(0, 0, 1, 5);
    ev(0, 0, 0, 5);
    drain();
    ev(0, 0, 1, 5);
    drain();
    for (int k = 0; k < 5; k++) begin
      {sv_t, sv_c} = {btype, bcap};
      case (k)
        0: btype[2:0] = 3'h4;
        1: btype[47:45] = 3'h1;
        2: bcap[15:0] = 16'd20001;
        3: bcap[63:0] = {4{16'd20000}};
        default: bcap = {208'h0, {3{16'd20000}}};
      endcase
      ms(1);
      chk(err === (k != 4), "config flag");
      {btype, bcap} = {sv_t, sv_c};
      ms(1);
      chk(err === 1'b0, "legal config");
    end
    print_verdict();
  end
endmodule
